// *** logic/ccr_pkg.sv ***
`default_nettype none
package ccr_pkg;
	// register port geometry
	localparam int          CCR_ADDR_W      = 6;
	localparam int          CCR_DATA_W      = 16;
	localparam int          CCR_NUM_CH      = 4;
	// register addresses
	localparam logic [5:0]  CCR_ADDR_ID     = 6'h07;
	localparam logic [5:0]  CCR_ADDR_CH0    = 6'h10;
	// reset values
	localparam logic [15:0] CCR_CH0_RESET   = 16'h8001;
	localparam logic [15:0] CCR_CHN_RESET   = 16'h0001;
	// writable bits: 15, 13:12, 9:0; reserved 14 and 11:10 stay zero
	localparam logic [15:0] CCR_WR_MASK     = 16'hB3FF;
	// field positions
	localparam int          CCR_EN_BIT      = 15;
	localparam int          CCR_PROF_HI     = 13;
	localparam int          CCR_PROF_LO     = 12;
	localparam int          CCR_POS_HI      = 9;
	localparam int          CCR_POS_LO      = 5;
	localparam int          CCR_NEG_HI      = 4;
	localparam int          CCR_NEG_LO      = 0;
	localparam int          CCR_PROF_W      = 2;
	localparam int          CCR_SEL_W       = 5;
endpackage
`default_nettype wire

// *** logic/ccr_sequencer.sv ***
`timescale 1ns/10ps
`default_nettype none
module ccr_sequencer
	import ccr_pkg::*;
#(
	parameter int NUM_CH = CCR_NUM_CH,
	parameter int IDX_W  = $clog2(NUM_CH)
)
(
	input  wire logic              sys_clk_in,
	input  wire logic              rstn_in,
	input  wire logic [NUM_CH-1:0] enable_in,
	input  wire logic              conv_done_in,
	output logic      [IDX_W-1:0]  active_ch_out,
	output logic                   active_valid_out
);
	// ==========================================
	// channel pointer
	logic [IDX_W-1:0] cur_ch;
	logic [IDX_W-1:0] next_cur_ch;
	logic             found;
	logic             advance;

	// RL4: auto sequencing
	// RL13: ascending with wrap
	always_comb
	begin
		next_cur_ch = cur_ch;
		found       = 1'b0;
		// a disabled current channel is left at once, not after its conversion
		advance     = conv_done_in || !enable_in[cur_ch];
		for (int i = 0; i < NUM_CH; i++)
		begin
			if (!found && enable_in[i] && (IDX_W'(i) > cur_ch))
			begin
				next_cur_ch = IDX_W'(i);
				found       = 1'b1;
			end
		end
		for (int i = 0; i < NUM_CH; i++)
		begin
			if (!found && enable_in[i])
			begin
				next_cur_ch = IDX_W'(i);
				found       = 1'b1;
			end
		end
		if (!advance || !found)
		begin
			next_cur_ch = cur_ch;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			cur_ch <= '0;
		end
		else
		begin
			cur_ch <= next_cur_ch;
		end
	end

	assign active_ch_out    = cur_ch;
	assign active_valid_out = enable_in[cur_ch];
endmodule
`default_nettype wire

// *** logic/ccr_channel_config_regs.sv ***
//
// Contract
// RL1: read-only fixed 16-bit part identifier
// RL2: channel zero at 0x10, resets 0x8001
// RL3: bit 15 enables channel, default on
// RL4: two or more enabled: auto sequence
// RL5: bit 14 reserved, reads zero
// RL6: bits 13:12 pick one of four setups
// RL7: setup selects its four-register group
// RL8: host writes same setup for sharing
// RL9: bits 11:10 reserved, read zero
// RL10: bits 9:5 pick positive input
// RL11: bits 4:0 pick negative input, default 1
// RL12: channels one to three at 0x11-0x13
// RL13: ascending channel order, wrap around
// RL14: writes to identifier are ignored
`timescale 1ns/10ps
`default_nettype none
module ccr_channel_config_regs
	import ccr_pkg::*;
#(
	// arbitrary neutral identifier value
	parameter logic [15:0] PART_ID = 16'h00A5,
	parameter int          NUM_CH  = CCR_NUM_CH,
	parameter int          IDX_W   = $clog2(NUM_CH)
)
(
	input  wire logic                  sys_clk_in,
	input  wire logic                  rstn_in,
	input  wire logic [CCR_ADDR_W-1:0] reg_addr_in,
	input  wire logic                  reg_wr_in,
	input  wire logic [CCR_DATA_W-1:0] reg_wdata_in,
	input  wire logic                  reg_rd_in,
	output logic      [CCR_DATA_W-1:0] reg_rdata_out,
	output logic                       reg_rvalid_out,
	input  wire logic                  conv_done_in,
	output logic      [IDX_W-1:0]      active_ch_out,
	output logic                       active_valid_out,
	output logic      [CCR_PROF_W-1:0] active_profile_out,
	output logic      [CCR_SEL_W-1:0]  active_pos_sel_out,
	output logic      [CCR_SEL_W-1:0]  active_neg_sel_out,
	output logic      [NUM_CH-1:0]     channel_enable_out
);
	// ==========================================
	// address decode
	logic [CCR_ADDR_W-1:0] ch_off;
	logic                  ch_hit;
	logic                  id_hit;

	// the offset wraps below the bank base, so the lower bound is tested apart
	assign ch_off = reg_addr_in - CCR_ADDR_CH0;
	assign ch_hit = (reg_addr_in >= CCR_ADDR_CH0) && (ch_off < CCR_ADDR_W'(NUM_CH));
	assign id_hit = (reg_addr_in == CCR_ADDR_ID);

	// ==========================================
	// channel register file
	logic [CCR_DATA_W-1:0] ch_cfg      [NUM_CH];
	logic [CCR_DATA_W-1:0] next_ch_cfg [NUM_CH];

	always_comb
	begin
		next_ch_cfg = ch_cfg;
		// RL14: identifier write dropped
		// RL12: channels by address offset
		if (reg_wr_in && ch_hit)
		begin
			// RL5: reserved bits masked
			// RL9: reserved bits masked
			next_ch_cfg[ch_off[IDX_W-1:0]] = reg_wdata_in & CCR_WR_MASK;
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			// RL2: channel zero default
			// RL12: others start disabled
			for (int i = 0; i < NUM_CH; i++)
			begin
				ch_cfg[i] <= (i == 0) ? CCR_CH0_RESET : CCR_CHN_RESET;
			end
		end
		else
		begin
			ch_cfg <= next_ch_cfg;
		end
	end

	// ==========================================
	// read port
	logic [CCR_DATA_W-1:0] rdata;
	logic [CCR_DATA_W-1:0] next_rdata;
	logic                  rvalid;
	logic                  next_rvalid;

	// a read in the same cycle as a write returns the old contents
	always_comb
	begin
		next_rdata  = rdata;
		next_rvalid = reg_rd_in;
		if (reg_rd_in)
		begin
			if (id_hit)
			begin
				// RL1: fixed identifier read
				next_rdata = PART_ID;
			end
			else if (ch_hit)
			begin
				next_rdata = ch_cfg[ch_off[IDX_W-1:0]];
			end
			else
			begin
				// unmapped reads answer zero
				next_rdata = '0;
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			rdata  <= '0;
			rvalid <= 1'b0;
		end
		else
		begin
			rdata  <= next_rdata;
			rvalid <= next_rvalid;
		end
	end

	assign reg_rdata_out  = rdata;
	assign reg_rvalid_out = rvalid;

	// ==========================================
	// enables and sequencing
	logic [NUM_CH-1:0] enables;

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++)
		begin : g_en
			// RL3: enable bit
			assign enables[g] = ch_cfg[g][CCR_EN_BIT];
		end
	endgenerate

	logic [IDX_W-1:0] seq_ch;
	logic             seq_valid;

	ccr_sequencer #(
		.NUM_CH (NUM_CH),
		.IDX_W  (IDX_W)
	) u_seq (
		.sys_clk_in       (sys_clk_in),
		.rstn_in          (rstn_in),
		.enable_in        (enables),
		.conv_done_in     (conv_done_in),
		.active_ch_out    (seq_ch),
		.active_valid_out (seq_valid)
	);

	// ==========================================
	// active channel outputs
	logic [IDX_W-1:0]      act_ch;
	logic                  act_valid;
	logic [CCR_PROF_W-1:0] act_prof;
	logic [CCR_SEL_W-1:0]  act_pos;
	logic [CCR_SEL_W-1:0]  act_neg;
	logic [NUM_CH-1:0]     act_en;
	logic [IDX_W-1:0]      next_act_ch;
	logic                  next_act_valid;
	logic [CCR_PROF_W-1:0] next_act_prof;
	logic [CCR_SEL_W-1:0]  next_act_pos;
	logic [CCR_SEL_W-1:0]  next_act_neg;
	logic [NUM_CH-1:0]     next_act_en;
	logic [CCR_DATA_W-1:0] sel_cfg;

	assign sel_cfg = ch_cfg[seq_ch];

	// outputs trail the pointer by one edge so they leave flip-flops, not the mux
	always_comb
	begin
		next_act_ch    = seq_ch;
		next_act_valid = seq_valid;
		// RL6: setup index
		// RL7: picks four-register group
		next_act_prof  = sel_cfg[CCR_PROF_HI:CCR_PROF_LO];
		// RL10: positive input
		next_act_pos   = sel_cfg[CCR_POS_HI:CCR_POS_LO];
		// RL11: negative input
		next_act_neg   = sel_cfg[CCR_NEG_HI:CCR_NEG_LO];
		next_act_en    = enables;
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			act_ch    <= '0;
			act_valid <= 1'b0;
			act_prof  <= '0;
			act_pos   <= '0;
			act_neg   <= '0;
			act_en    <= '0;
		end
		else
		begin
			act_ch    <= next_act_ch;
			act_valid <= next_act_valid;
			act_prof  <= next_act_prof;
			act_pos   <= next_act_pos;
			act_neg   <= next_act_neg;
			act_en    <= next_act_en;
		end
	end

	assign active_ch_out      = act_ch;
	assign active_valid_out   = act_valid;
	assign active_profile_out = act_prof;
	assign active_pos_sel_out = act_pos;
	assign active_neg_sel_out = act_neg;
	assign channel_enable_out = act_en;
endmodule
`default_nettype wire

// *** tb/ccr_sva.sv ***
`timescale 1ns/10ps
`default_nettype none
// ====
// port checks
module ccr_sva
	import ccr_pkg::*;
#(parameter logic [15:0] PART_ID = 16'h0000)
(
	input wire logic        sys_clk_in,
	input wire logic        rstn_in,
	input wire logic [5:0]  reg_addr_in,
	input wire logic        reg_wr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic        reg_rd_in,
	input wire logic [15:0] reg_rdata_out,
	input wire logic        reg_rvalid_out,
	input wire logic [1:0]  active_ch_out,
	input wire logic        active_valid_out,
	input wire logic [3:0]  channel_enable_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);
	sequence s_wr_ch0;
		reg_wr_in && reg_addr_in == CCR_ADDR_CH0;
	endsequence
	a_rvalid_after: assert property (reg_rd_in |=> reg_rvalid_out)
		else $error("rvalid late");
	a_rvalid_cause: assert property (reg_rvalid_out |-> $past(reg_rd_in))
		else $error("rvalid stray");
	a_id_fixed: assert property (reg_rd_in && reg_addr_in == CCR_ADDR_ID |=> reg_rdata_out == PART_ID)
		else $error("bad id");
	a_resv_zero: assert property (reg_rvalid_out |-> reg_rdata_out[14] == 0 && reg_rdata_out[11:10] == 0)
		else $error("reserved set");
	a_rdata_holds: assert property (!$past(reg_rd_in) |-> $stable(reg_rdata_out))
		else $error("rdata moved");
	a_enable_follows: assert property (s_wr_ch0 |=> ##1 channel_enable_out[0] == $past(reg_wdata_in[15], 2))
		else $error("enable stale");
	a_none_idle: assert property ((channel_enable_out == 0)[*3] |-> !active_valid_out)
		else $error("valid with none");
	a_single_stays: assert property ($onehot(channel_enable_out)[*4] |-> active_valid_out && channel_enable_out[active_ch_out])
		else $error("wrong single");
endmodule
bind ccr_channel_config_regs ccr_sva #(.PART_ID(PART_ID)) u_ccr_sva (.*);
`default_nettype wire

// *** tb/ccr_host.sv ***
`timescale 1ns/10ps
`default_nettype none
// ====
// host model
module ccr_host
(
	input  wire logic        sys_clk_in,
	input  wire logic [15:0] rdata_in,
	input  wire logic        rvalid_in,
	output logic      [5:0]  addr_out,
	output logic             wr_out,
	output logic      [15:0] wdata_out,
	output logic             rd_out
);
	initial
	begin
		{addr_out, wr_out, wdata_out, rd_out} = '0;
	end
	task automatic acc(input logic w, input logic [5:0] a, input logic [15:0] d,
		output logic [15:0] q, output logic v);
		@(negedge sys_clk_in);
		addr_out = a;
		wdata_out = d;
		wr_out = w;
		rd_out = !w;
		// taken at the rising edge; the one-cycle answer stands until the next one
		@(negedge sys_clk_in);
		q = rdata_in;
		v = rvalid_in;
		// released address and data lines show the inverse, not the old value; wr and rd drop to zero
		addr_out = ~a;
		wdata_out = ~d;
		wr_out = 0;
		rd_out = 0;
	endtask
endmodule
`default_nettype wire

// *** tb/channel_config_regs_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module channel_config_regs_bench;
	import ccr_pkg::*;
	// ====
	// model and stimulus
	localparam logic [15:0] PART_ID = 16'h005A; // arbitrary value
	logic        sys_clk_in, rstn_in, conv_done_in, reg_wr_in, reg_rd_in, reg_rvalid_out, v;
	logic        active_valid_out;
	logic [5:0]  reg_addr_in;
	logic [15:0] reg_wdata_in, reg_rdata_out, q;
	logic [15:0] m[4];
	logic [1:0]  active_ch_out, active_profile_out;
	logic [4:0]  active_pos_sel_out, active_neg_sel_out;
	logic [3:0]  channel_enable_out;
	int          n_mismatch, samples_checked, seed, p, k, r;
	int          al[6] = '{7, 16, 17, 18, 19, 63};
	ccr_channel_config_regs #(.PART_ID(PART_ID)) u_ccr_channel_config_regs (
		.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
		.reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
		.conv_done_in(conv_done_in), .active_ch_out(active_ch_out),
		.active_valid_out(active_valid_out), .active_profile_out(active_profile_out),
		.active_pos_sel_out(active_pos_sel_out), .active_neg_sel_out(active_neg_sel_out),
		.channel_enable_out(channel_enable_out));
	ccr_host u_ccr_host (.sys_clk_in(sys_clk_in), .rdata_in(reg_rdata_out),
		.rvalid_in(reg_rvalid_out), .addr_out(reg_addr_in), .wr_out(reg_wr_in),
		.wdata_out(reg_wdata_in), .rd_out(reg_rd_in));
	task automatic chk(input logic [15:0] e, input logic [15:0] g, input string s);
		samples_checked++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	function automatic int nxt(input int c);
		for (int i = 1; i <= 4; i++)
			if (m[(c + i) % 4][15])
				return (c + i) % 4;
		return c;
	endfunction
	task automatic wrm(input logic [5:0] a, input logic [15:0] d);
		u_ccr_host.acc(1'b1, a, d, q, v);
		if (a > 15 && a < 20)
			m[a - 16] = d & CCR_WR_MASK;
		if (!m[p][15])
			p = nxt(p);
	endtask
	task automatic rdall;
		foreach (al[i])
		begin
			u_ccr_host.acc(1'b0, 6'(al[i]), 16'h0000, q, v);
			chk(16'h0001, {15'h0, v}, "rvalid");
			chk(al[i] == 7 ? PART_ID : (al[i] > 15 && al[i] < 20) ? m[al[i] - 16] : 16'h0000, q, "rdata");
		end
	endtask
	task automatic cmp;
		chk({15'h0, m[0][15] | m[1][15] | m[2][15] | m[3][15]}, {15'h0, active_valid_out}, "valid");
		chk({12'h0, m[3][15], m[2][15], m[1][15], m[0][15]}, {12'h0, channel_enable_out}, "enables");
		if (active_valid_out === 1'b1)
		begin
			chk(16'(p), {14'h0, active_ch_out}, "chan");
			chk({4'h0, m[p][13:12], m[p][9:0]}, {4'h0, active_profile_out, active_pos_sel_out, active_neg_sel_out}, "fields");
		end
	endtask
	task automatic seq;
		repeat (3) @(negedge sys_clk_in);
		cmp;
		for (int i = 0; i < 5; i++)
		begin
			conv_done_in = 1;
			@(negedge sys_clk_in);
			conv_done_in = 0;
			p = nxt(p);
			@(negedge sys_clk_in);
			cmp;
		end
	endtask
	initial
	begin
		sys_clk_in = 0;
		forever #25 sys_clk_in = ~sys_clk_in;
	end
	initial
	begin
		#1000000;
		n_mismatch++;
		conclude;
	end
	initial
	begin
		seed = 53717;
		rstn_in = 0;
		conv_done_in = 0;
		p = 0;
		m = '{16'h8001, 16'h0001, 16'h0001, 16'h0001};
		repeat (4) @(negedge sys_clk_in);
		rstn_in = 1;
		rdall;
		wrm(6'h07, 16'hFFFF);
		wrm(6'h25, 16'hFFFF);
		wrm(6'h11, 16'hFFFF);
		rdall;
		seq;
		for (k = 0; k < 4; k++)
			wrm(6'(16 + k), 16'(32'h8000 | k << 12 | k << 5 | 3 - k));
		seq;
		// one shared setup on every enabled channel
		for (k = 0; k < 4; k++)
			wrm(6'(16 + k), 16'(32'hA000 | k << 5 | k));
		seq;
		for (r = 0; r < 8; r++)
		begin
			for (k = 0; k < 4; k++)
				wrm(6'(16 + k), 16'($random(seed)));
			rdall;
			seq;
		end
		for (k = 0; k < 4; k++)
			wrm(6'(16 + k), 16'h0000);
		seq;
		conclude;
	end
endmodule
`default_nettype wire
